// >>> hdl/tpeic_top.sv
// Purpose: Trap and port edge interrupt controller with APB registers.
// Assumes: Core strobes are one-cycle pulses synchronous to sys_clk_in.
// Notes:   Trap pending state is internal and has no register.
`timescale 1ns/1ps
`default_nettype none
module tpeic_top
    import tpeic_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic pready_out,
    output logic [31:0] prdata_out,
    output logic pslverr_out,
    // Core sequencer
    input wire tpeic_core_in_type core_in,
    output var tpeic_core_out_type core_out,
    // Port pins
    input wire logic [7:0] port_pin_in
);
    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic trap_pending_flag;
        logic global_irq_enable;
        logic port_group_irq_enable;
        logic [7:0] wake_enable_reg;
        logic [7:0] wake_edge_select_reg;
        logic in_service;
        logic irq_req;
        logic vec_valid;
        logic [7:0] vec_low;
        logic wake;
        logic wake_isr;
        logic woke;
    } tpeic_state_type;

    tpeic_state_type st;
    tpeic_state_type next_st;
    logic [7:0] wake_pending_reg;
    logic [7:0] pend_clear;
    logic f_instr_valid;
    logic [7:0] f_instr;
    logic f_trap;
    logic [14:0] f_trap_addr;
    logic f_pc_force;
    logic wr_go;
    logic port_req;
    logic mask_ok;

    tpeic_fetch u_fetch (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .core_in(core_in),
        .instr_valid_out(f_instr_valid),
        .instr_out(f_instr),
        .trap_out(f_trap),
        .trap_addr_out(f_trap_addr),
        .pc_force_valid_out(f_pc_force)
    );

    for (genvar i = 0; i < 8; i++) begin : g_pin
        tpeic_wake_cell u_cell (
            .sys_clk_in(sys_clk_in),
            .rstn_in(rstn_in),
            .pin_in(port_pin_in[i]),
            .edge_sel_in(st.wake_edge_select_reg[i]),
            .clear_in(pend_clear[i]),
            .pending_out(wake_pending_reg[i])
        );
    end

    always_comb begin
        next_st = st;
        wr_go = psel_in && penable_in && st.pready && pwrite_in;
        pend_clear = '0;
        port_req = |(wake_pending_reg & st.wake_enable_reg);
        // APB, zero wait, answer in access phase
        next_st.pready = psel_in && !penable_in;
        next_st.pslverr = 1'b0;
        next_st.prdata = '0;
        if (psel_in && !penable_in) begin
            unique case (paddr_in)
                TPEIC_REG_WAKE_EN: begin
                    next_st.prdata[7:0] = st.wake_enable_reg;
                end
                TPEIC_REG_WAKE_EDGE: begin
                    next_st.prdata[7:0] = st.wake_edge_select_reg;
                end
                TPEIC_REG_WAKE_PEND: begin
                    next_st.prdata[7:0] = wake_pending_reg;
                end
                TPEIC_REG_CTRL: begin
                    next_st.prdata[TPEIC_CTRL_GIE_BIT] =
                        st.global_irq_enable;
                    next_st.prdata[TPEIC_CTRL_PGE_BIT] =
                        st.port_group_irq_enable;
                end
                TPEIC_REG_STATUS: begin
                    // Trap pending deliberately not visible
                    next_st.prdata[TPEIC_STAT_BOOT_BIT] =
                        core_in.boot_rom;
                    next_st.prdata[TPEIC_STAT_SERV_BIT] = st.in_service;
                    next_st.prdata[TPEIC_STAT_REQ_BIT] = port_req;
                end
                default: begin
                    next_st.pslverr = 1'b1;
                end
            endcase
        end
        if (wr_go) begin
            unique case (paddr_in)
                TPEIC_REG_WAKE_EN: begin
                    next_st.wake_enable_reg = pwdata_in[7:0];
                end
                TPEIC_REG_WAKE_EDGE: begin
                    next_st.wake_edge_select_reg = pwdata_in[7:0];
                end
                TPEIC_REG_WAKE_PEND: begin
                    pend_clear = pwdata_in[7:0];
                end
                TPEIC_REG_CTRL: begin
                    next_st.global_irq_enable =
                        pwdata_in[TPEIC_CTRL_GIE_BIT];
                    next_st.port_group_irq_enable =
                        pwdata_in[TPEIC_CTRL_PGE_BIT];
                end
                default: begin
                end
            endcase
        end
        // Maskable service bookkeeping
        if (core_in.irq_taken) begin
            next_st.in_service = 1'b1;
            next_st.global_irq_enable = 1'b0;
        end
        if (core_in.return_from_irq_instr) begin
            next_st.in_service = 1'b0;
            next_st.global_irq_enable = 1'b1;
        end
        // Trap pending: set wins over clear; enable left alone
        if (core_in.clear_pending_instr) begin
            next_st.trap_pending_flag = 1'b0;
        end
        if (f_trap) begin
            next_st.trap_pending_flag = 1'b1;
        end
        mask_ok = st.global_irq_enable && st.port_group_irq_enable &&
                  port_req;
        next_st.irq_req = mask_ok && !st.trap_pending_flag &&
                          !core_in.boot_rom &&
                          !st.in_service;
        // Arbitration result on vector select
        next_st.vec_valid = core_in.vector_select_instr;
        if (core_in.vector_select_instr) begin
            if (st.trap_pending_flag) begin
                next_st.vec_low = TPEIC_VEC_TRAP;
            end else if (st.port_group_irq_enable && port_req) begin
                next_st.vec_low = TPEIC_VEC_PORT;
            end else begin
                next_st.vec_low = TPEIC_VEC_DEFAULT;
            end
        end
        // Wake from halt or idle, once per stay
        next_st.wake = core_in.halt_idle && port_req && !st.woke;
        next_st.wake_isr = core_in.halt_idle && port_req && !st.woke &&
                           mask_ok;
        next_st.woke = core_in.halt_idle && (st.woke || port_req);
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st <= '0;
            st.global_irq_enable <= TPEIC_RST_GIE;
            st.port_group_irq_enable <= TPEIC_RST_PGE;
            st.wake_enable_reg <= TPEIC_RST_WAKE_EN;
            st.wake_edge_select_reg <= TPEIC_RST_WAKE_EDGE;
        end else begin
            st <= next_st;
        end
    end

    assign pready_out = st.pready;
    assign prdata_out = st.prdata;
    assign pslverr_out = st.pslverr;
    always_comb begin
        core_out.instr_valid = f_instr_valid;
        core_out.instr = f_instr;
        core_out.trap_ack = f_trap;
        core_out.trap_ret_addr = f_trap_addr;
        core_out.pc_force_valid = f_pc_force;
        core_out.pc_force = TPEIC_PC_OVERPOP;
        core_out.irq_req = st.irq_req;
        core_out.vec_valid = st.vec_valid;
        core_out.vec_low = st.vec_low;
        core_out.wake = st.wake;
        core_out.wake_isr = st.wake_isr;
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    AST_TRAP_SET: assert property (
        core_in.fetch_valid &&
        core_in.fetch_data == TPEIC_TRAP_OPCODE
        |=> ##1 st.trap_pending_flag)
        else $error("trap fetch did not set pending");
    AST_TRAP_HOLD: assert property (
        st.trap_pending_flag && !core_in.clear_pending_instr
        |=> st.trap_pending_flag)
        else $error("trap pending dropped without clear");
    AST_TRAP_CLEAR: assert property (
        core_in.clear_pending_instr && !f_trap |=> !st.trap_pending_flag)
        else $error("clear did not drop trap pending");
    AST_TRAP_BLOCKS: assert property (
        st.trap_pending_flag |=> !core_out.irq_req)
        else $error("maskable request during trap");
    AST_TRAP_GIE: assert property (
        f_trap && !wr_go && !core_in.irq_taken &&
        !core_in.return_from_irq_instr
        |=> st.global_irq_enable == $past(st.global_irq_enable))
        else $error("trap changed global enable");
    AST_VEC_TRAP: assert property (
        core_in.vector_select_instr && st.trap_pending_flag
        |=> core_out.vec_valid && core_out.vec_low == TPEIC_VEC_TRAP)
        else $error("vector select missed trap vector");
    AST_BOOT_BLOCK: assert property (
        core_in.boot_rom |=> !core_out.irq_req)
        else $error("request while in boot rom");
    AST_NO_PREEMPT: assert property (
        st.in_service |=> !core_out.irq_req)
        else $error("maskable preempted maskable");
    AST_OVERPOP: assert property (
        core_in.pop_valid && core_in.pop_sp > TPEIC_STACK_LIMIT
        |=> core_out.pc_force_valid &&
            core_out.pc_force == TPEIC_PC_OVERPOP)
        else $error("stack overpop not forced");
    AST_RET_ADDR: assert property (
        core_in.fetch_valid |=> core_out.trap_ret_addr ==
                                $past(core_in.fetch_addr))
        else $error("trap return address wrong");
    AST_PORT_REQ: assert property (
        mask_ok && !st.trap_pending_flag && !core_in.boot_rom &&
        !st.in_service |=> core_out.irq_req)
        else $error("port request not raised");
    AST_RESET_FLAG: assert property (
        disable iff (1'b0)
        !rstn_in |-> !st.trap_pending_flag && !core_out.irq_req)
        else $error("reset left trap pending or request");
    AST_TRAP_ACK: assert property (
        core_in.fetch_valid && core_in.fetch_data == TPEIC_TRAP_OPCODE
        |=> core_out.trap_ack && core_out.instr == TPEIC_TRAP_OPCODE)
        else $error("zero opcode fetch not trapped");
    AST_BEYOND_FLASH: assert property (
        core_in.fetch_valid && core_in.fetch_addr > TPEIC_FLASH_LAST
        |=> core_out.trap_ack && core_out.instr == TPEIC_TRAP_OPCODE)
        else $error("fetch beyond flash not trapped");
    AST_NO_FALSE_TRAP: assert property (
        core_in.fetch_valid && core_in.fetch_data != TPEIC_TRAP_OPCODE &&
        core_in.fetch_addr <= TPEIC_FLASH_LAST
        |=> !core_out.trap_ack &&
            core_out.instr == $past(core_in.fetch_data))
        else $error("flash byte altered or trapped");
    AST_TRAP_IN_SERVICE: assert property (
        st.in_service && core_out.trap_ack |=> st.trap_pending_flag)
        else $error("trap did not preempt maskable routine");
    AST_VEC_PORT: assert property (
        core_in.vector_select_instr && !st.trap_pending_flag &&
        st.port_group_irq_enable && port_req
        |=> core_out.vec_valid && core_out.vec_low == TPEIC_VEC_PORT)
        else $error("vector select missed port vector");
    AST_VEC_DEFAULT: assert property (
        core_in.vector_select_instr && !st.trap_pending_flag &&
        !(st.port_group_irq_enable && port_req)
        |=> core_out.vec_valid && core_out.vec_low == TPEIC_VEC_DEFAULT)
        else $error("vector select missed default vector");
    AST_GROUP_GATE: assert property (
        !st.global_irq_enable || !st.port_group_irq_enable
        |=> !core_out.irq_req)
        else $error("request with an enable low");
    AST_REQ_NEEDS_PEND: assert property (
        !port_req |=> !core_out.irq_req)
        else $error("request without enabled pending bit");
    AST_PEND_KEEP: assert property (
        !wr_go |=> (wake_pending_reg & $past(wake_pending_reg)) ==
                   $past(wake_pending_reg))
        else $error("pending bit lost without a clear");
    AST_WAKE_ONE: assert property (
        core_in.halt_idle && port_req && !st.woke
        |=> core_out.wake && core_out.wake_isr == $past(mask_ok))
        else $error("wake or its service choice wrong");
    AST_WAKE_ONCE: assert property (
        core_out.wake && core_in.halt_idle |=> !core_out.wake)
        else $error("wake repeated within one halt stay");
    AST_BOOT_GIE: assert property (
        core_in.boot_rom && !wr_go && !core_in.irq_taken &&
        !core_in.return_from_irq_instr
        |=> st.global_irq_enable == $past(st.global_irq_enable))
        else $error("boot rom changed global enable");
    AST_APB_READY: assert property (
        psel_in && !penable_in |=> pready_out)
        else $error("register access not answered");
    AST_HIDDEN_FLAG: assert property (
        psel_in && !penable_in && paddr_in == TPEIC_REG_STATUS
        |=> prdata_out[31:3] == 29'h0)
        else $error("status shows more than its three bits");
    AST_UNMAPPED: assert property (
        psel_in && !penable_in && paddr_in > TPEIC_REG_STATUS
        |=> pslverr_out && prdata_out == 32'h0)
        else $error("unmapped address not refused");
endmodule
`default_nettype wire

// >>> hdl/tpeic_pkg.sv
// Purpose: Shared constants and carriers of the trap and port edge
//          interrupt controller.
// Assumes: One 100 MHz clock, APB register access.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
package tpeic_pkg;
    // Opcodes and vector bytes
    localparam logic [7:0] TPEIC_TRAP_OPCODE = 8'h00;
    localparam logic [7:0] TPEIC_VEC_TRAP = 8'hFE;
    localparam logic [7:0] TPEIC_VEC_PORT = 8'hE2;
    localparam logic [7:0] TPEIC_VEC_DEFAULT = 8'hE0;
    // Memory limits
    localparam logic [7:0] TPEIC_STACK_LIMIT = 8'h6F;
    localparam logic [14:0] TPEIC_PC_OVERPOP = 15'h7FFF;
    localparam logic [14:0] TPEIC_FLASH_LAST = 15'h1FFF;
    // Register offsets
    localparam logic [7:0] TPEIC_REG_WAKE_EN = 8'h00;
    localparam logic [7:0] TPEIC_REG_WAKE_EDGE = 8'h04;
    localparam logic [7:0] TPEIC_REG_WAKE_PEND = 8'h08;
    localparam logic [7:0] TPEIC_REG_CTRL = 8'h0C;
    localparam logic [7:0] TPEIC_REG_STATUS = 8'h10;
    // Field positions
    localparam int TPEIC_CTRL_GIE_BIT = 0;
    localparam int TPEIC_CTRL_PGE_BIT = 1;
    localparam int TPEIC_STAT_BOOT_BIT = 0;
    localparam int TPEIC_STAT_SERV_BIT = 1;
    localparam int TPEIC_STAT_REQ_BIT = 2;
    // Reset values
    localparam logic [7:0] TPEIC_RST_WAKE_EN = 8'h00;
    localparam logic [7:0] TPEIC_RST_WAKE_EDGE = 8'h00;
    localparam logic TPEIC_RST_GIE = 1'b0;
    localparam logic TPEIC_RST_PGE = 1'b0;

    typedef struct packed {
        logic fetch_valid;
        logic [14:0] fetch_addr;
        logic [7:0] fetch_data;
        logic pop_valid;
        logic [7:0] pop_sp;
        logic clear_pending_instr;
        logic vector_select_instr;
        logic irq_taken;
        logic return_from_irq_instr;
        logic boot_rom;
        logic halt_idle;
    } tpeic_core_in_type;

    typedef struct packed {
        logic instr_valid;
        logic [7:0] instr;
        logic trap_ack;
        logic [14:0] trap_ret_addr;
        logic pc_force_valid;
        logic [14:0] pc_force;
        logic irq_req;
        logic vec_valid;
        logic [7:0] vec_low;
        logic wake;
        logic wake_isr;
    } tpeic_core_out_type;
endpackage

// >>> hdl/tpeic_wake_cell.sv
// Purpose: One port pin edge detector with pending latch.
// Assumes: Pin level synchronous to the clock.
// Notes:   Edge select low picks rising, high picks falling.
`timescale 1ns/1ps
`default_nettype none
module tpeic_wake_cell
    import tpeic_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // Pin and control
    input wire logic pin_in,
    input wire logic edge_sel_in,
    input wire logic clear_in,
    // Status
    output logic pending_out
);
    typedef struct packed {
        logic primed;
        logic prev;
        logic pend;
    } tpeic_cell_type;

    tpeic_cell_type st;
    tpeic_cell_type next_st;
    logic hit;

    always_comb begin
        next_st = st;
        hit = st.primed && (edge_sel_in ? (st.prev && !pin_in)
                                        : (!st.prev && pin_in));
        next_st.primed = 1'b1;
        next_st.prev = pin_in;
        // Set wins; a repeat while pending is simply absorbed
        next_st.pend = (st.pend && !clear_in) || hit;
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pending_out = st.pend;
endmodule
`default_nettype wire

// >>> hdl/tpeic_fetch.sv
// Purpose: Fetch filter, trap detect and stack overpop guard.
// Assumes: Core presents fetch data and pops as one-cycle strobes.
// Notes:   Outputs are registered, one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module tpeic_fetch
    import tpeic_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // Core side
    input wire tpeic_core_in_type core_in,
    // Results
    output logic instr_valid_out,
    output logic [7:0] instr_out,
    output logic trap_out,
    output logic [14:0] trap_addr_out,
    output logic pc_force_valid_out
);
    typedef struct packed {
        logic instr_valid;
        logic [7:0] instr;
        logic trap;
        logic [14:0] addr;
        logic pc_force_valid;
    } tpeic_fetch_type;

    tpeic_fetch_type st;
    tpeic_fetch_type next_st;
    logic [7:0] byte_seen;

    always_comb begin
        next_st = st;
        byte_seen = core_in.fetch_data;
        if (core_in.fetch_addr > TPEIC_FLASH_LAST) begin
            byte_seen = TPEIC_TRAP_OPCODE;
        end
        if (core_in.fetch_addr == TPEIC_PC_OVERPOP) begin
            byte_seen = TPEIC_TRAP_OPCODE;
        end
        next_st.instr_valid = core_in.fetch_valid;
        next_st.trap = core_in.fetch_valid &&
                       (byte_seen == TPEIC_TRAP_OPCODE);
        if (core_in.fetch_valid) begin
            next_st.instr = byte_seen;
            next_st.addr = core_in.fetch_addr;
        end
        next_st.pc_force_valid = core_in.pop_valid &&
                                 (core_in.pop_sp > TPEIC_STACK_LIMIT);
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign instr_valid_out = st.instr_valid;
    assign instr_out = st.instr;
    assign trap_out = st.trap;
    assign trap_addr_out = st.addr;
    assign pc_force_valid_out = st.pc_force_valid;
endmodule
`default_nettype wire

// >>> testbench/tpeic_core_model.sv
// Purpose: Core sequencer and port pin model for the trap controller.
// Assumes: Strobes are launched just after a rising edge.
// Notes:   Released fetch data shows the inverse of the last byte.
`timescale 1ns/1ps
`default_nettype none
module tpeic_core_model
    import tpeic_pkg::*;
(
    // Clock
    input wire logic sys_clk_in,
    // Core strobes and pins
    output var tpeic_core_in_type core_req_out,
    output logic [7:0] pins_out
);
    initial begin
        core_req_out = '0;
        pins_out = 8'h00;
    end
    task fetch(input logic [14:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        core_req_out.fetch_valid <= 1'b1;
        core_req_out.fetch_addr <= a;
        core_req_out.fetch_data <= d;
        @(posedge sys_clk_in);
        core_req_out.fetch_valid <= 1'b0;
        core_req_out.fetch_data <= ~d;
    endtask
    task pop(input logic [7:0] sp);
        @(posedge sys_clk_in);
        core_req_out.pop_valid <= 1'b1;
        core_req_out.pop_sp <= sp;
        @(posedge sys_clk_in);
        core_req_out.pop_valid <= 1'b0;
        core_req_out.pop_sp <= ~sp;
    endtask
    // Bits: return, taken, vector select, clear pending
    task pulse(input logic [3:0] m);
        @(posedge sys_clk_in);
        {core_req_out.return_from_irq_instr, core_req_out.irq_taken,
            core_req_out.vector_select_instr,
            core_req_out.clear_pending_instr} <= m;
        @(posedge sys_clk_in);
        {core_req_out.return_from_irq_instr, core_req_out.irq_taken,
            core_req_out.vector_select_instr,
            core_req_out.clear_pending_instr} <= 4'h0;
    endtask
    // Trap routine clears twice before restart or skip return
    task clear_trap;
        pulse(4'h1);
        pulse(4'h1);
    endtask
    task levels(input logic boot, input logic halt);
        @(posedge sys_clk_in);
        core_req_out.boot_rom <= boot;
        core_req_out.halt_idle <= halt;
    endtask
    task pins(input logic [7:0] v);
        @(posedge sys_clk_in);
        pins_out <= v;
    endtask
endmodule
`default_nettype wire

// >>> testbench/tpeic_top_tb.sv
// Purpose: Self-checking bench of the trap and port edge controller.
// Assumes: Single-cycle APB answer, registered core outputs.
// Notes:   Drivers queue expectations, a monitor compares them.
`timescale 1ns/1ps
`default_nettype none
module tpeic_top_tb;
    import tpeic_pkg::*;
    logic clk, rstn, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr;
    tpeic_core_in_type cin;
    tpeic_core_out_type cout;
    logic [7:0] pins;
    logic [32:0] q[5][$];
    logic [31:0] seed = 32'hD2FF239A;
    logic [14:0] a;
    int n_errors = 0;
    int checked = 0;

    tpeic_top tpeic_top_i (.sys_clk_in(clk), .rstn_in(rstn),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
        .prdata_out(prdata), .pslverr_out(pslverr), .core_in(cin),
        .core_out(cout), .port_pin_in(pins));
    tpeic_core_model tpeic_core_model_i (.sys_clk_in(clk),
        .core_req_out(cin), .pins_out(pins));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        give_verdict();
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task give_verdict;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task take(input int k, input string nm, input logic [32:0] g);
        if (q[k].size() == 0) begin
            chk(nm, 33'h1DEADBEEF, g);
        end else begin
            chk(nm, q[k].pop_front(), g);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) begin
            @(posedge clk);
        end
        if (i == 20) begin
            n_errors++;
            give_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] ad, input logic [31:0] d);
        bus(1'b1, ad, d);
    endtask
    task rd(input logic [7:0] ad, input logic [31:0] e);
        q[0].push_back({ad > TPEIC_REG_STATUS, e});
        bus(1'b0, ad, 32'h0);
    endtask
    task lvl(input string nm, input logic e);
        chk(nm, {32'h0, e}, {32'h0, cout.irq_req});
    endtask

    always @(posedge clk) begin
        if (rstn) begin
            if (psel && penable && pready && !pwrite)
                take(0, "apb read", {pslverr, prdata});
            if (cout.trap_ack)
                take(1, "trap addr", {18'h0, cout.trap_ret_addr});
            if (cout.vec_valid)
                take(2, "vector", {25'h0, cout.vec_low});
            if (cout.pc_force_valid)
                take(3, "pc force", {18'h0, cout.pc_force});
            if (cout.wake)
                take(4, "wake isr", {32'h0, cout.wake_isr});
        end
    end

    initial begin
        rstn = 1'b0;
        {psel, penable, pwrite} = 3'b000;
        paddr = 8'h00;
        pwdata = 32'h0;
        cyc(2);
        rstn <= 1'b1;
        rd(TPEIC_REG_WAKE_EN, 32'h0);
        rd(TPEIC_REG_WAKE_EDGE, 32'h0);
        rd(TPEIC_REG_WAKE_PEND, 32'h0);
        rd(TPEIC_REG_CTRL, 32'h0);
        rd(8'h14 | (8'(rnd()) & 8'hE8), 32'h0);
        pwdata <= rnd();
        wr(TPEIC_REG_WAKE_EN, seed);
        rd(TPEIC_REG_WAKE_EN, {24'h0, seed[7:0]});
        wr(TPEIC_REG_WAKE_EN, 32'h09);
        wr(TPEIC_REG_WAKE_EDGE, 32'h08);
        $display("test registers done");
        a = 15'(rnd() & 32'h1FFF);
        q[1].push_back({18'h0, a});
        tpeic_core_model_i.fetch(a, TPEIC_TRAP_OPCODE);
        tpeic_core_model_i.fetch(a ^ 15'h1, 8'(rnd()) | 8'h01);
        q[1].push_back(33'h2000);
        tpeic_core_model_i.fetch(15'h2000, 8'h5A);
        q[1].push_back(33'h7FFF);
        tpeic_core_model_i.fetch(TPEIC_PC_OVERPOP, 8'h33);
        tpeic_core_model_i.pop(TPEIC_STACK_LIMIT);
        q[3].push_back({18'h0, TPEIC_PC_OVERPOP});
        tpeic_core_model_i.pop(8'h70 | 8'(rnd()));
        cyc(3);
        q[2].push_back({25'h0, TPEIC_VEC_TRAP});
        tpeic_core_model_i.pulse(4'h2);
        $display("test trap sources done");
        wr(TPEIC_REG_CTRL, 32'h3);
        tpeic_core_model_i.pins(8'h09);
        tpeic_core_model_i.pins(8'h01);
        cyc(3);
        rd(TPEIC_REG_WAKE_PEND, 32'h09);
        lvl("irq_req", 1'b0);
        rd(TPEIC_REG_STATUS, 32'h4);
        tpeic_core_model_i.clear_trap();
        cyc(3);
        lvl("irq_req", 1'b1);
        q[2].push_back({25'h0, TPEIC_VEC_PORT});
        tpeic_core_model_i.pulse(4'h2);
        wr(TPEIC_REG_CTRL, 32'h1);
        cyc(2);
        lvl("irq_req", 1'b0);
        q[2].push_back({25'h0, TPEIC_VEC_DEFAULT});
        tpeic_core_model_i.pulse(4'h2);
        wr(TPEIC_REG_CTRL, 32'h3);
        $display("test port edges done");
        tpeic_core_model_i.pulse(4'h4);
        cyc(2);
        lvl("irq_req", 1'b0);
        rd(TPEIC_REG_CTRL, 32'h2);
        q[1].push_back({18'h0, a});
        tpeic_core_model_i.fetch(a, TPEIC_TRAP_OPCODE);
        cyc(3);
        q[2].push_back({25'h0, TPEIC_VEC_TRAP});
        tpeic_core_model_i.pulse(4'h2);
        tpeic_core_model_i.clear_trap();
        tpeic_core_model_i.pulse(4'h8);
        cyc(3);
        lvl("irq_req", 1'b1);
        $display("test service done");
        tpeic_core_model_i.levels(1'b1, 1'b0);
        cyc(2);
        lvl("irq_req", 1'b0);
        rd(TPEIC_REG_CTRL, 32'h3);
        rd(TPEIC_REG_STATUS, 32'h5);
        tpeic_core_model_i.pins(8'h09);
        tpeic_core_model_i.pins(8'h01);
        cyc(2);
        rd(TPEIC_REG_WAKE_PEND, 32'h09);
        tpeic_core_model_i.levels(1'b0, 1'b0);
        cyc(2);
        lvl("irq_req", 1'b1);
        $display("test boot rom done");
        q[4].push_back(33'h1);
        tpeic_core_model_i.levels(1'b0, 1'b1);
        cyc(3);
        tpeic_core_model_i.levels(1'b0, 1'b0);
        wr(TPEIC_REG_CTRL, 32'h1);
        q[4].push_back(33'h0);
        tpeic_core_model_i.levels(1'b0, 1'b1);
        cyc(3);
        tpeic_core_model_i.levels(1'b0, 1'b0);
        wr(TPEIC_REG_WAKE_PEND, 32'h09);
        rd(TPEIC_REG_WAKE_PEND, 32'h0);
        cyc(3);
        $display("test wake done");
        for (int k = 0; k < 5; k++) begin
            chk("pending notes", 33'h0, 33'(q[k].size()));
        end
        give_verdict();
    end
endmodule
`default_nettype wire
